/* design/sfi_device.sv */
// sfi_device: serial flash command front end and status bytes
`timescale 1ns/100ps
module sfi_device (
   input  wire logic        rst,
   sfi_link_if.dev          link,
   output      logic [7:0]  status_one,
   output      logic [7:0]  status_two,
   output      logic        op_start,
   output      logic [2:0]  op_kind,
   output      logic [23:0] op_addr,
   output      logic        four_wire_cmd_mode,
   output      logic        deep_down
);
   logic        write_latch;
   logic        lock_mode_bit0;
   logic        lock_mode_bit1;
   logic        quad_enable;
   logic        paused_op_flag;
   logic        busy;
   logic [15:0] busy_cnt;
   logic [15:0] powerup_write_delay;
   logic        rst_armed;
   logic [7:0]  opcode;
   logic [7:0]  shreg;
   logic [5:0]  bitcnt;
   logic [23:0] addr;
   logic [7:0]  wr1;
   logic [7:0]  wr2;
   logic [7:0]  rd_shift;
   logic [8:0]  pg_cnt;
   logic        op_done;
   logic [3:0]  dout;
   logic [3:0]  doe;
   sfi_pkg::sfi_lane_type lane;
   logic        sel;
   logic        op_valid;
   logic        byte_done;
   logic        wr_ok;
   logic        sr_ok;
   logic        cmd_ok;
   logic [7:0]  next_byte;
   logic        rd_load;

   assign sel = ~link.cs_n;
   // four-wire mode takes four bits per edge, so the opcode ends after two clocks
   assign lane = four_wire_cmd_mode ? sfi_pkg::SFI_LANE_X4 : sfi_pkg::SFI_LANE_X1;
   assign op_valid = (four_wire_cmd_mode && bitcnt == 6'h1) || (!four_wire_cmd_mode && bitcnt == 6'h7);
   assign next_byte = four_wire_cmd_mode ? {shreg[3:0], link.io} : {shreg[6:0], link.io[0]};
   assign wr_ok = (powerup_write_delay == 16'h0000);
   // lock mode decode with the protect pin only in control role
   always_comb
   begin
      case ({lock_mode_bit1, lock_mode_bit0})
         sfi_pkg::LOCK_SW: sr_ok = write_latch;
         sfi_pkg::LOCK_HW: sr_ok = write_latch && (quad_enable || link.wp_n_pin);
         default:          sr_ok = 1'b0;
      endcase
   end
   // filter on the opcode: busy, deep power-down and quad rules
   always_comb
   begin
      cmd_ok = 1'b1;
      if (deep_down && next_byte != sfi_pkg::CMD_RDPD)
         cmd_ok = 1'b0;
      else if (busy && next_byte != sfi_pkg::CMD_RDSR1 && next_byte != sfi_pkg::CMD_RDSR2
               && next_byte != sfi_pkg::CMD_SUSP)
         cmd_ok = 1'b0;
      else if (!quad_enable && (next_byte == sfi_pkg::CMD_QPI_ON || next_byte == sfi_pkg::CMD_QREAD
               || next_byte == sfi_pkg::CMD_QPP))
         cmd_ok = 1'b0;
   end

   // input shift on rising edge; select high clears the frame
   always_ff @(posedge link.sck or posedge link.cs_n or posedge rst)
   begin
      if (rst || link.cs_n)
      begin
         bitcnt <= 6'h00;
         shreg  <= 8'h00;
         opcode <= 8'h00;
      end
      else
      begin
         shreg  <= next_byte;
         if (bitcnt != 6'h3f)
            bitcnt <= bitcnt + 6'h01;
         if (op_valid)
            opcode <= cmd_ok ? next_byte : 8'h00;
      end
   end
   assign byte_done = four_wire_cmd_mode ? bitcnt[0] : (bitcnt[2:0] == 3'h7);
   // first falling edge after a byte boundary launches the msb of the answer
   assign rd_load = four_wire_cmd_mode ? !bitcnt[0] : (bitcnt[2:0] == 3'h0);

   // address and payload capture after the opcode
   always_ff @(posedge link.sck or posedge rst)
   begin
      if (rst)
      begin
         addr   <= 24'h000000;
         wr1    <= 8'h00;
         wr2    <= 8'h00;
         pg_cnt <= 9'h000;
      end
      else if (sel && byte_done && !op_valid)
      begin
         if (bitcnt < (four_wire_cmd_mode ? 6'h08 : 6'h20))
            addr <= {addr[15:0], next_byte};
         else if (pg_cnt != sfi_pkg::PAGE_BYTES)
            pg_cnt <= pg_cnt + 9'h001;
         if (bitcnt == (four_wire_cmd_mode ? 6'h03 : 6'h0f))
            wr1 <= next_byte;
         if (bitcnt == (four_wire_cmd_mode ? 6'h05 : 6'h17))
            wr2 <= next_byte;
      end
      else if (!sel)
         pg_cnt <= 9'h000;
   end

   // command execution at select rising edge; write latch and modes
   always_ff @(posedge link.cs_n or posedge rst)
   begin
      if (rst)
      begin
         write_latch        <= 1'b0;
         four_wire_cmd_mode <= 1'b0;
         deep_down          <= 1'b0;
         rst_armed          <= 1'b0;
         lock_mode_bit0     <= 1'b0;
         lock_mode_bit1     <= 1'b0;
         quad_enable        <= sfi_pkg::QE_RESET;
         paused_op_flag     <= 1'b0;
         op_start           <= 1'b0;
         op_kind            <= sfi_pkg::SFI_OP_NONE;
         op_addr            <= 24'h000000;
      end
      else
      begin
         op_start  <= 1'b0;
         rst_armed <= (opcode == sfi_pkg::CMD_RSTEN);
         case (opcode)
            sfi_pkg::CMD_WREN:    if (wr_ok) write_latch <= 1'b1;
            sfi_pkg::CMD_WRDI:    write_latch <= 1'b0;
            sfi_pkg::CMD_QPI_ON:  four_wire_cmd_mode <= 1'b1;
            sfi_pkg::CMD_QPI_OFF: four_wire_cmd_mode <= 1'b0;
            sfi_pkg::CMD_RST:     if (rst_armed) four_wire_cmd_mode <= 1'b0;
            sfi_pkg::CMD_DPD:     deep_down <= 1'b1;
            sfi_pkg::CMD_RDPD:    deep_down <= 1'b0;
            sfi_pkg::CMD_SUSP:    if (busy) paused_op_flag <= 1'b1;
            sfi_pkg::CMD_RESUME:  paused_op_flag <= 1'b0;
            sfi_pkg::CMD_WRSR1, sfi_pkg::CMD_WRSR2:
            begin
               if (sr_ok && wr_ok)
               begin
                  if (opcode == sfi_pkg::CMD_WRSR1)
                  begin
                     lock_mode_bit0 <= wr1[sfi_pkg::BIT_LM0];
                     lock_mode_bit1 <= wr2[sfi_pkg::BIT_LM1];
                     quad_enable    <= wr2[sfi_pkg::BIT_QE];
                  end
                  else
                  begin
                     lock_mode_bit1 <= wr1[sfi_pkg::BIT_LM1];
                     quad_enable    <= wr1[sfi_pkg::BIT_QE];
                  end
                  op_start <= 1'b1;
                  op_kind  <= sfi_pkg::SFI_OP_WSR;
               end
               write_latch <= 1'b0;
            end
            sfi_pkg::CMD_PP, sfi_pkg::CMD_QPP, sfi_pkg::CMD_SE4, sfi_pkg::CMD_BE32,
            sfi_pkg::CMD_BE64, sfi_pkg::CMD_CE1, sfi_pkg::CMD_CE2, sfi_pkg::CMD_WRSEC:
            begin
               if (write_latch && wr_ok)
               begin
                  op_start <= 1'b1;
                  case (opcode)
                     sfi_pkg::CMD_SE4:
                     begin
                        op_kind <= sfi_pkg::SFI_OP_E4;
                        op_addr <= sfi_pkg::sfi_align(addr, sfi_pkg::MASK_4K);
                     end
                     sfi_pkg::CMD_BE32:
                     begin
                        op_kind <= sfi_pkg::SFI_OP_E32;
                        op_addr <= sfi_pkg::sfi_align(addr, sfi_pkg::MASK_32K);
                     end
                     sfi_pkg::CMD_BE64:
                     begin
                        op_kind <= sfi_pkg::SFI_OP_E64;
                        op_addr <= sfi_pkg::sfi_align(addr, sfi_pkg::MASK_64K);
                     end
                     sfi_pkg::CMD_CE1, sfi_pkg::CMD_CE2:
                     begin
                        op_kind <= sfi_pkg::SFI_OP_CHIP;
                        op_addr <= 24'h000000;
                     end
                     sfi_pkg::CMD_WRSEC: op_kind <= sfi_pkg::SFI_OP_SEC;
                     default:
                     begin
                        op_kind <= sfi_pkg::SFI_OP_PROG; // page base only
                        op_addr <= sfi_pkg::sfi_align(addr, sfi_pkg::MASK_PG);
                     end
                  endcase
               end
               write_latch <= 1'b0;
            end
            default: ;
         endcase
      end
   end

   // busy timer and power-up write delay, counted on the serial clock
   always_ff @(posedge link.sck or posedge rst)
   begin
      if (rst)
      begin
         busy_cnt            <= 16'h0000;
         powerup_write_delay <= sfi_pkg::PUW_CLKS;
         op_done             <= 1'b1;
      end
      else
      begin
         if (powerup_write_delay != 16'h0000)
            powerup_write_delay <= powerup_write_delay - 16'h0001;
         // start seen on the first clock of the next frame; busy holds while paused
         if (op_start && op_done)
         begin
            busy_cnt <= sfi_pkg::BUSY_CLKS;
            op_done  <= 1'b0;
         end
         else if (!op_done && !paused_op_flag)
         begin
            if (busy_cnt == 16'h0000)
               op_done <= 1'b1;
            else
               busy_cnt <= busy_cnt - 16'h0001;
         end
      end
   end
   // busy already from the executing select edge, before the counter sees a clock
   assign busy = !op_done || op_start;

   assign status_one = {lock_mode_bit0, 5'h00, write_latch, busy};
   assign status_two = {paused_op_flag, 5'h00, quad_enable, lock_mode_bit1};

   // output shift on falling edge
   always_ff @(negedge link.sck or posedge link.cs_n or posedge rst)
   begin
      if (rst || link.cs_n)
      begin
         rd_shift <= 8'h00;
         dout     <= 4'h0;
         doe      <= 4'h0;
      end
      else if (opcode == sfi_pkg::CMD_RDSR1 || opcode == sfi_pkg::CMD_RDSR2)
      begin
         if (rd_load)
            rd_shift <= (opcode == sfi_pkg::CMD_RDSR1) ? status_one : status_two;
         if (four_wire_cmd_mode)
         begin
            dout     <= rd_load ? ((opcode == sfi_pkg::CMD_RDSR1) ? status_one[7:4]
                                                                   : status_two[7:4])
                                  : rd_shift[3:0];
            doe      <= 4'hf;
         end
         else
         begin
            dout     <= {3'h0, rd_load ? ((opcode == sfi_pkg::CMD_RDSR1) ? status_one[7]
                                                                        : status_two[7])
                                       : rd_shift[6]};
            if (!rd_load)
               rd_shift <= {rd_shift[6:0], 1'b0};
            doe      <= 4'h2;
         end
      end
      else
         doe <= 4'h0;
   end
   // single-lane data goes out on io1 in standard mode
   assign link.io_dev_o  = (lane == sfi_pkg::SFI_LANE_X4) ? dout : {2'h0, dout[0], 1'b0};
   assign link.io_dev_oe = doe;
endmodule // sfi_device

/* design/sfi_host.sv */
// sfi_host: host end that frames one command onto the serial pins
`timescale 1ns/100ps
module sfi_host (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   sfi_link_if.host         link,
   input  wire logic        req,
   input  wire logic [7:0]  cmd,
   input  wire logic [2:0]  nbytes,
   input  wire logic [31:0] payload,
   input  wire logic        quad_cmd,
   output      logic        ready,
   output      logic [7:0]  rd_data,
   output      logic        done
);
   typedef enum logic [1:0] {
      SFI_H_IDLE = 2'b00,
      SFI_H_LOW  = 2'b01,
      SFI_H_HIGH = 2'b10,
      SFI_H_END  = 2'b11
   } sfi_hstate_type;
   sfi_hstate_type state;
   logic [39:0] shreg;
   logic [5:0]  bits_left;
   logic [3:0]  div;
   logic        sck_q;
   logic [2:0]  io_sync;
   assign ready = (state == SFI_H_IDLE);
   // divided clock, idle low: mode 0
   assign link.sck = sck_q;
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         state      <= SFI_H_IDLE;
         shreg      <= 40'h0;
         bits_left  <= 6'h00;
         div        <= 4'h0;
         sck_q      <= 1'b0;
         link.cs_n  <= 1'b1;
         rd_data    <= 8'h00;
         done       <= 1'b0;
         io_sync    <= 3'h0;
      end
      else
      begin
         done    <= 1'b0;
         io_sync <= {io_sync[1:0], link.io[1]};
         case (state)
            SFI_H_IDLE:
               if (req)
               begin
                  shreg     <= {cmd, payload}; // opcode msb first
                  bits_left <= quad_cmd ? {nbytes, 1'b0} + 6'h02 : {nbytes, 3'h0} + 6'h08;
                  link.cs_n <= 1'b0;
                  div       <= 4'h0;
                  state     <= SFI_H_LOW;
               end
            SFI_H_LOW:
               if (div == sfi_pkg::HOST_DIV)
               begin
                  div   <= 4'h0;
                  sck_q <= 1'b1;
                  state <= SFI_H_HIGH;
               end
               else
                  div <= div + 4'h1;
            SFI_H_HIGH:
               if (div == sfi_pkg::HOST_DIV)
               begin
                  div       <= 4'h0;
                  sck_q     <= 1'b0;
                  rd_data   <= {rd_data[6:0], io_sync[2]};
                  shreg     <= quad_cmd ? {shreg[35:0], 4'h0} : {shreg[38:0], 1'b0};
                  bits_left <= bits_left - 6'h01;
                  state     <= (bits_left == 6'h01) ? SFI_H_END : SFI_H_LOW;
               end
               else
                  div <= div + 4'h1;
            SFI_H_END:
            begin
               link.cs_n <= 1'b1;
               done      <= 1'b1;
               state     <= SFI_H_IDLE;
            end
            default: state <= SFI_H_IDLE;
         endcase
      end
   end
   // data changes while clock low, stable at rising edge
   assign link.io_host_o  = quad_cmd ? shreg[39:36] : {3'h7, shreg[39]};
   assign link.io_host_oe = (state == SFI_H_IDLE || state == SFI_H_END) ? 4'h0
                          : (quad_cmd ? 4'hf : 4'h1);
endmodule // sfi_host

/* design/sfi_link_if.sv */
// sfi_link_if: the serial pins between host and flash
`timescale 1ns/100ps
interface sfi_link_if;
   logic       sck;
   logic       cs_n;
   logic [3:0] io_host_o;
   logic [3:0] io_host_oe;
   logic [3:0] io_dev_o;
   logic [3:0] io_dev_oe;
   logic [3:0] io;
   logic       wp_n_pin;
   logic       hold_n_pin;
   // wire level: drivers resolve, undriven lines pulled high
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         io[i] = io_host_oe[i] ? io_host_o[i] : (io_dev_oe[i] ? io_dev_o[i] : 1'b1);
      end
      wp_n_pin   = io[2];
      hold_n_pin = io[3];
   end
   modport host (output sck, output cs_n, output io_host_o, output io_host_oe, input io);
   modport dev  (input sck, input cs_n, output io_dev_o, output io_dev_oe, input io,
                 input wp_n_pin, input hold_n_pin);
endinterface

/* design/sfi_pkg.sv */
// sfi_pkg: shared constants for the serial flash front end
package sfi_pkg;
   localparam logic [7:0] CMD_WREN     = 8'h06;
   localparam logic [7:0] CMD_WRDI     = 8'h04;
   localparam logic [7:0] CMD_RDSR1    = 8'h05;
   localparam logic [7:0] CMD_RDSR2    = 8'h35;
   localparam logic [7:0] CMD_WRSR1    = 8'h01;
   localparam logic [7:0] CMD_WRSR2    = 8'h31;
   localparam logic [7:0] CMD_PP       = 8'h02;
   localparam logic [7:0] CMD_QPP      = 8'h33;
   localparam logic [7:0] CMD_SE4      = 8'h20;
   localparam logic [7:0] CMD_BE32     = 8'h52;
   localparam logic [7:0] CMD_BE64     = 8'hd8;
   localparam logic [7:0] CMD_CE1      = 8'h60;
   localparam logic [7:0] CMD_CE2      = 8'hc7;
   localparam logic [7:0] CMD_SUSP     = 8'h75;
   localparam logic [7:0] CMD_RESUME   = 8'h7a;
   localparam logic [7:0] CMD_DPD      = 8'hb9;
   localparam logic [7:0] CMD_RDPD     = 8'hab;
   localparam logic [7:0] CMD_QPI_ON   = 8'h38;
   localparam logic [7:0] CMD_QPI_OFF  = 8'hff;
   localparam logic [7:0] CMD_RSTEN    = 8'h66;
   localparam logic [7:0] CMD_RST      = 8'h99;
   localparam logic [7:0] CMD_WRSEC    = 8'h2f;
   localparam logic [7:0] CMD_READ     = 8'h03;
   localparam logic [7:0] CMD_DREAD    = 8'h3b;
   localparam logic [7:0] CMD_QREAD    = 8'h6b;
   // status bit positions
   localparam int BIT_BUSY   = 0;
   localparam int BIT_WL     = 1;
   localparam int BIT_LM0    = 7;
   localparam int BIT_LM1    = 0;
   localparam int BIT_QE     = 1;
   localparam int BIT_SUS    = 7;
   localparam logic        QE_RESET = 1'b1;
   localparam logic [1:0]  LOCK_SW  = 2'h0;
   localparam logic [1:0]  LOCK_HW  = 2'h1;
   localparam logic [1:0]  LOCK_PWR = 2'h2;
   localparam int ADDR_W      = 24;
   localparam logic [23:0] MASK_4K  = 24'h000fff;
   localparam logic [23:0] MASK_32K = 24'h007fff;
   localparam logic [23:0] MASK_64K = 24'h00ffff;
   localparam logic [23:0] MASK_PG  = 24'h0000ff;
   localparam logic [8:0]  PAGE_BYTES = 9'h100;
   // serial clocks counted for busy time and power-up delay
   localparam logic [15:0] BUSY_CLKS    = 16'h0040;
   localparam logic [15:0] PUW_CLKS     = 16'h0020;
   localparam logic [3:0]  HOST_DIV     = 4'h1;
   typedef enum logic [1:0] {
      SFI_LANE_X1 = 2'b00,
      SFI_LANE_X2 = 2'b01,
      SFI_LANE_X4 = 2'b10
   } sfi_lane_type;
   typedef enum logic [2:0] {
      SFI_OP_NONE  = 3'b000,
      SFI_OP_PROG  = 3'b001,
      SFI_OP_E4    = 3'b010,
      SFI_OP_E32   = 3'b011,
      SFI_OP_E64   = 3'b100,
      SFI_OP_CHIP  = 3'b101,
      SFI_OP_WSR   = 3'b110,
      SFI_OP_SEC   = 3'b111
   } sfi_op_type;
   function automatic logic [23:0] sfi_align(input logic [23:0] a, input logic [23:0] m);
      sfi_align = a & ~m;
   endfunction
endpackage

/* tb/sfi_assertions.sv */
// sfi_assertions: wire-level checks on the host to flash link
`timescale 1ns/100ps
module sfi_assertions (
   input wire logic       clk_sys,
   input wire logic       rst,
   input wire logic       sck,
   input wire logic       cs_n,
   input wire logic [3:0] io_host_o,
   input wire logic [3:0] io_host_oe,
   input wire logic [3:0] io_dev_o,
   input wire logic [3:0] io_dev_oe
);
   logic [7:0] rises;

   // sck rising edges seen inside the current frame
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         rises <= 8'h00;
      else if (cs_n)
         rises <= 8'h00;
      else if ($rose(sck))
         rises <= rises + 8'h01;
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   a_sck_idle_low: assert property (cs_n |-> !sck)
      else $error("serial clock high while deselected");
   a_select_fall: assert property ($fell(cs_n) |-> !sck [*2])
      else $error("serial clock not low after select fell");
   a_host_launch: assert property ((!cs_n && $changed(io_host_o)) |-> !sck)
      else $error("host data moved while serial clock high");
   a_dev_launch: assert property ((io_dev_oe[1] && $past(io_dev_oe[1]) && $changed(io_dev_o[1]))
      |-> $fell(sck))
      else $error("device data moved off a falling clock");
   a_dev_release: assert property ((cs_n && $past(cs_n)) |-> io_dev_oe == 4'h0)
      else $error("device drives while deselected");
   a_no_fight: assert property ((io_host_oe & io_dev_oe) == 4'h0)
      else $error("host and device drive one line");
   a_frame_whole: assert property ($rose(cs_n) |-> rises != 8'h00 && rises[0] == 1'b0)
      else $error("frame ended on a partial clock pair");
   a_sck_pace: assert property ($rose(sck) |-> sck [*2] ##1 !sck)
      else $error("serial clock high phase wrong length");
   // checked during reset itself, so reset must not disable it
   a_reset_silent: assert property (disable iff (1'b0) rst |-> io_dev_oe == 4'h0)
      else $error("device drives during reset");

   c_frame_end: cover property ($rose(cs_n));
   c_dev_drive: cover property ($rose(io_dev_oe[1]));
   c_quad_host: cover property (io_host_oe == 4'hf);
endmodule // sfi_assertions

/* tb/tb.sv */
// tb: both link ends joined, driven from the host user side
`timescale 1ns/100ps
module tb;
   logic        clk_sys;
   logic        rst;
   logic        req;
   logic [7:0]  cmd;
   logic [2:0]  nbytes;
   logic [31:0] payload;
   logic        quad_cmd;
   logic        ready;
   logic        done;
   logic [7:0]  rd_data;
   logic [7:0]  status_one;
   logic [7:0]  status_two;
   logic [2:0]  op_kind;
   logic [23:0] op_addr;
   logic        four_wire_cmd_mode;
   logic        deep_down;
   int          error_cnt;
   int          compares;

   sfi_link_if link ();
   sfi_host sfi_host_inst (.clk_sys(clk_sys), .rst(rst), .link(link), .req(req), .cmd(cmd),
      .nbytes(nbytes), .payload(payload), .quad_cmd(quad_cmd), .ready(ready),
      .rd_data(rd_data), .done(done));
   sfi_device sfi_device_inst (.rst(rst), .link(link), .status_one(status_one),
      .status_two(status_two), .op_start(), .op_kind(op_kind), .op_addr(op_addr),
      .four_wire_cmd_mode(four_wire_cmd_mode), .deep_down(deep_down));
   sfi_assertions sfi_assertions_inst (.clk_sys(clk_sys), .rst(rst), .sck(link.sck),
      .cs_n(link.cs_n), .io_host_o(link.io_host_o), .io_host_oe(link.io_host_oe),
      .io_dev_o(link.io_dev_o), .io_dev_oe(link.io_dev_oe));

   always #25 clk_sys = ~clk_sys;

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one whole frame; request fields held until done
   task automatic xfer(input logic [7:0] c, input logic [2:0] n, input logic [31:0] p,
                       input logic q);
      int k;
      k = 0;
      while (ready !== 1'b1 && k < 100)
      begin
         @(negedge clk_sys);
         k++;
      end
      @(posedge clk_sys);
      req <= 1'b1;
      cmd <= c;
      nbytes <= n;
      payload <= p;
      quad_cmd <= q;
      @(posedge clk_sys);
      req <= 1'b0;
      k = 0;
      do
      begin
         @(negedge clk_sys);
         k++;
      end
      while (done !== 1'b1 && k < 2000);
      chk(24'(done), 24'h1);
   endtask

   task automatic wren();
      xfer(sfi_pkg::CMD_WREN, 3'h0, 32'h0, 1'b0);
   endtask

   // polls keep sck running, which the busy count needs
   task automatic wait_idle();
      int k;
      k = 0;
      do
      begin
         xfer(sfi_pkg::CMD_RDSR1, 3'h1, 32'h0, 1'b0);
         k++;
      end
      while (rd_data[0] !== 1'b0 && k < 12);
      chk(24'(status_one[0]), 24'h0);
   endtask

   task automatic s_powerup();
      wren();
      chk(24'(status_one), 24'h0);
      xfer(sfi_pkg::CMD_RDSR1, 3'h1, 32'h0, 1'b0);
      chk(24'(rd_data), 24'h0);
      xfer(sfi_pkg::CMD_RDSR2, 3'h1, 32'h0, 1'b0);
      chk(24'(rd_data), 24'({6'h0, sfi_pkg::QE_RESET, 1'b0}));
   endtask

   task automatic s_latch();
      wren();
      chk(24'(status_one), 24'h2);
      xfer(sfi_pkg::CMD_RDSR1, 3'h1, 32'h0, 1'b0);
      chk(24'(rd_data), 24'h2);
      xfer(sfi_pkg::CMD_WRDI, 3'h0, 32'h0, 1'b0);
      chk(24'(status_one), 24'h0);
   endtask

   task automatic s_ops();
      logic [7:0] ops [6] = '{sfi_pkg::CMD_PP, sfi_pkg::CMD_SE4, sfi_pkg::CMD_BE32,
                             sfi_pkg::CMD_BE64, sfi_pkg::CMD_CE1, sfi_pkg::CMD_CE2};
      logic [2:0] kind [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h5};
      logic [23:0] base [4] = '{24'h3fe900, 24'h3fe000, 24'h3f8000, 24'h3f0000};
      for (int i = 0; i < 6; i++)
      begin
         wren();
         xfer(ops[i], (i == 0) ? 3'h4 : 3'h3, 32'h3fe9ab5a, 1'b0);
         chk(24'(op_kind), 24'(kind[i]));
         if (i < 4)
            chk(op_addr, base[i]);
         chk(24'(status_one), 24'h1);
         wren();
         chk(24'(status_one), 24'h1);
         wait_idle();
         chk(24'(status_one), 24'h0);
      end
   endtask

   // lock mode 10 refuses status register writes until the next reset
   task automatic s_lock();
      wren();
      xfer(sfi_pkg::CMD_WRSR1, 3'h2, 32'h00030000, 1'b0);
      wait_idle();
      chk(24'(status_two), 24'h3);
      wren();
      xfer(sfi_pkg::CMD_WRSR2, 3'h1, 32'h02000000, 1'b0);
      wait_idle();
      chk(24'(status_two), 24'h3);
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      @(negedge clk_sys);
      chk(24'(status_two), 24'h2);
      s_powerup();
   endtask

   task automatic s_dpd();
      xfer(sfi_pkg::CMD_DPD, 3'h0, 32'h0, 1'b0);
      chk(24'(deep_down), 24'h1);
      wren();
      chk(24'(status_one), 24'h0);
      xfer(sfi_pkg::CMD_RDPD, 3'h3, 32'h0, 1'b0);
      chk(24'(deep_down), 24'h0);
   endtask

   task automatic s_quad();
      wren();
      xfer(sfi_pkg::CMD_WRSR2, 3'h1, 32'h0, 1'b0);
      wait_idle();
      xfer(sfi_pkg::CMD_QPI_ON, 3'h0, 32'h0, 1'b0);
      chk(24'(four_wire_cmd_mode), 24'h0);
      wren();
      xfer(sfi_pkg::CMD_WRSR2, 3'h1, 32'h02000000, 1'b0);
      wait_idle();
      chk(24'(status_two), 24'h2);
      xfer(sfi_pkg::CMD_QPI_ON, 3'h0, 32'h0, 1'b0);
      chk(24'(four_wire_cmd_mode), 24'h1);
      xfer(sfi_pkg::CMD_QPI_OFF, 3'h0, 32'h0, 1'b1);
      chk(24'(four_wire_cmd_mode), 24'h0);
      xfer(sfi_pkg::CMD_QPI_ON, 3'h0, 32'h0, 1'b0);
      xfer(sfi_pkg::CMD_RSTEN, 3'h0, 32'h0, 1'b1);
      xfer(sfi_pkg::CMD_RST, 3'h0, 32'h0, 1'b1);
      chk(24'(four_wire_cmd_mode), 24'h0);
   endtask

   task automatic print_verdict();
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial
   begin
      clk_sys = 1'b0;
      rst = 1'b1;
      req = 1'b0;
      cmd = 8'h00;
      nbytes = 3'h0;
      payload = 32'h0;
      quad_cmd = 1'b0;
      error_cnt = 0;
      compares = 0;
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      @(negedge clk_sys);
      chk(24'({status_two, status_one}), 24'h0200);
      chk(24'({four_wire_cmd_mode, deep_down}), 24'h0);
      s_powerup();
      s_latch();
      s_ops();
      s_lock();
      s_dpd();
      s_quad();
      print_verdict();
   end

   // generous bound: the full sequence needs far fewer cycles
   initial
   begin
      repeat (60000) @(posedge clk_sys);
      error_cnt++;
      print_verdict();
   end
endmodule // tb
